// File: common/sds_pkg.sv
`default_nettype none
package sds_pkg;
  // clock and brake timing
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned BRAKE_STEP_NS     = 10_000_000;
  localparam int unsigned BRAKE_STEP_CYCLES = BRAKE_STEP_NS / CLK_PERIOD_NS;

  // field widths
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned THR_W   = 8;
  localparam int unsigned LIMIT_W = 8;
  localparam int unsigned MODE_W  = 4;
  localparam int unsigned MT_W    = 16;
  localparam int unsigned CMD_W   = 32;

  // multiturn limits
  localparam logic signed [MT_W-1:0] MT_MAX   = 16'sh7FFF;
  localparam logic signed [MT_W-1:0] MT_MIN   = 16'sh8000;
  localparam logic signed [MT_W-1:0] MT_RESET = 16'sh0000;

  // power loss and encoder usage encodings
  localparam logic PLOSS_CONTINUE = 1'h0;
  localparam logic PLOSS_ALARM    = 1'h1;
  localparam logic ENC_ABSOLUTE   = 1'h0;
  localparam logic ENC_INCREMENT  = 1'h1;

  // control modes that take the analog speed reference
  localparam logic [MODE_W-1:0] MODE_SPEED   = 4'h0;
  localparam logic [MODE_W-1:0] MODE_ANA_4   = 4'h4;
  localparam logic [MODE_W-1:0] MODE_ANA_7   = 4'h7;
  localparam logic [MODE_W-1:0] MODE_ANA_9   = 4'h9;
  localparam logic [MODE_W-1:0] MODE_ANA_A   = 4'hA;

  typedef enum logic [1:0] {
    BRK_RELEASED = 2'h0,
    BRK_WAIT     = 2'h1,
    BRK_APPLIED  = 2'h2
  } sds_brake_e;

  function automatic logic sds_mode_is_analog(input logic [MODE_W-1:0] m);
    return (m == MODE_SPEED) || (m == MODE_ANA_4) || (m == MODE_ANA_7) ||
           (m == MODE_ANA_9) || (m == MODE_ANA_A);
  endfunction
endpackage
`default_nettype wire

// File: common/sds_enc_if.sv
`default_nettype none
interface sds_enc_if;
  import sds_pkg::*;
  logic                   turnFwd;
  logic                   turnRev;
  logic                   setupAccept;
  logic                   batClear;
  logic                   batLowIn;
  logic                   batDeadIn;
  logic                   intFaultIn;
  logic                   absMode;
  logic signed [MT_W-1:0] count;
  logic                   almBatLow;
  logic                   almBatDead;
  logic                   almInternal;
  logic                   dataLost;

  modport sup (
    output turnFwd, turnRev, setupAccept, batClear, batLowIn, batDeadIn,
           intFaultIn, absMode,
    input  count, almBatLow, almBatDead, almInternal, dataLost
  );
  modport enc (
    input  turnFwd, turnRev, setupAccept, batClear, batLowIn, batDeadIn,
           intFaultIn, absMode,
    output count, almBatLow, almBatDead, almInternal, dataLost
  );
endinterface
`default_nettype wire

// File: design/sds_multiturn.sv
`default_nettype none
module sds_multiturn (
  input  wire logic clk_sys,
  input  wire logic nrst,
  sds_enc_if.enc    enc
);
  import sds_pkg::*;

  typedef struct packed {
    logic signed [MT_W-1:0] count;
    logic                   almLow;
    logic                   almDead;
    logic                   almInt;
    logic                   lost;
  } sds_mt_s;

  sds_mt_s q, d;
  logic    absOn;

  // incremental use needs no battery, so battery alarms stay quiet
  // mode gating
  assign absOn = (enc.absMode == ENC_ABSOLUTE);

  always_comb begin
    d = q;
    if (enc.turnFwd && !enc.turnRev) begin
      d.count = (q.count == MT_MAX) ? MT_MIN : q.count + 16'sh0001;
    end else if (enc.turnRev && !enc.turnFwd) begin
      d.count = (q.count == MT_MIN) ? MT_MAX : q.count - 16'sh0001;
    end
    if (enc.setupAccept) begin
      d.count   = MT_RESET;
      d.almDead = 1'b0;
      d.lost    = 1'b0;
    end
    if (enc.batClear) begin
      d.almLow = 1'b0;
    end
    if (absOn && enc.batLowIn) begin
      d.almLow = 1'b1;
    end
    if (absOn && enc.batDeadIn) begin
      d.almDead = 1'b1;
      d.lost    = 1'b1;
    end
    if (enc.intFaultIn) begin
      d.almInt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '{count: MT_RESET, almLow: 1'b0, almDead: 1'b0,
             almInt: 1'b0, lost: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign enc.count       = q.count;
  assign enc.almBatLow   = q.almLow;
  assign enc.almBatDead  = q.almDead;
  assign enc.almInternal = q.almInt;
  assign enc.dataLost    = q.lost;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_fwd_at_top;
    q.count == MT_MAX && enc.turnFwd && !enc.turnRev && !enc.setupAccept;
  endsequence
  property p_wrap_fwd;
    s_fwd_at_top |=> (q.count == MT_MIN);
  endproperty
  a_wrap_fwd: assert property (p_wrap_fwd)
    else $error("multiturn did not wrap to lower limit");

  property p_wrap_rev;
    (q.count == MT_MIN && enc.turnRev && !enc.turnFwd && !enc.setupAccept)
      |=> (q.count == MT_MAX);
  endproperty
  a_wrap_rev: assert property (p_wrap_rev)
    else $error("multiturn did not wrap to upper limit");

  property p_low_sticky;
    q.almLow && !enc.batClear |=> q.almLow;
  endproperty
  a_low_sticky: assert property (p_low_sticky)
    else $error("battery low alarm cleared without utility");

  property p_dead_lost;
    (absOn && enc.batDeadIn) |=> (q.almDead && q.lost) [*2];
  endproperty
  a_dead_lost: assert property (p_dead_lost)
    else $error("dead battery did not mark multiturn lost");

  property p_internal_latch;
    q.almInt |=> q.almInt;
  endproperty
  a_internal_latch: assert property (p_internal_latch)
    else $error("internal encoder alarm cleared before power off");

  property p_incr_quiet;
    (!absOn && !q.almLow && !q.almDead) |=> !$rose(q.almLow | q.almDead);
  endproperty
  a_incr_quiet: assert property (p_incr_quiet)
    else $error("battery alarm raised in incremental mode");
endmodule
`default_nettype wire

// File: design/sds_supervisor.sv
// Notes on behaviour
// - brake output high applies the holding brake, low releases it.
// - after servo off while running, brake when speed drops below threshold.
// - also apply brake when brake time limit passes, whichever comes first.
// - main power dip: select 0 keeps running, select 1 alarms and servo off.
// - multiturn count past +32767 forward becomes -32768.
// - multiturn count past -32768 reverse becomes +32767.
// - absolute position is readable; host reads it with servo off.
// - encoder usage 0 is absolute, 1 is incremental without battery.
// - encoder usage change applies only after a power cycle.
// - battery below about 3.1V raises battery-low alarm.
// - battery below about 2.5V raises battery-dead alarm, multiturn lost.
// - battery-low alarm clears only by battery alarm clear utility.
// - encoder setup accepted only with servo off.
// - encoder alarms ignore alarm reset; setup clears battery-dead and multiturn lost.
// - internal encoder alarms stay latched until power removal.
// - gain select low gives P control, high gives PI control.
// - analog speed reference used only in modes 0, 4, 7, 9, A.
// - speed command is reference times speed input gain while servo on in those modes, else zero.
// - any alarm except battery-low turns servo off at once, then brake timing starts.
`default_nettype none
module sds_supervisor #(
  parameter int unsigned BRAKE_STEP = sds_pkg::BRAKE_STEP_CYCLES
) (
  input  wire logic                           clk_sys,
  input  wire logic                           nrst,
  input  wire logic                           servoOnReq,
  input  wire logic                           alarmIn,
  input  wire logic                           alarmResetInputN,
  input  wire logic [sds_pkg::SPEED_W-1:0]    motorSpeed,
  input  wire logic [sds_pkg::THR_W-1:0]      brakeSpeedThreshold,
  input  wire logic [sds_pkg::LIMIT_W-1:0]    brakeTimeLimit,
  input  wire logic                           powerLossSelect,
  input  wire logic                           mainPowerDip,
  input  wire logic                           encoderUsageSelect,
  input  wire logic                           turnFwd,
  input  wire logic                           turnRev,
  input  wire logic                           batteryLowIn,
  input  wire logic                           batteryDeadIn,
  input  wire logic                           encoderFaultIn,
  input  wire logic                           encoderSetupUtility,
  input  wire logic                           batteryAlarmClearUtility,
  input  wire logic                           gainSelectInputN,
  input  wire logic [sds_pkg::MODE_W-1:0]     controlModeSelect,
  input  wire logic signed [sds_pkg::SPEED_W-1:0] speedRefIn,
  input  wire logic [sds_pkg::SPEED_W-1:0]    speedInputGain,
  output logic                                brakeInterlockOut,
  output logic                                servoActive,
  output logic                                powerLossAlarm,
  output logic                                batteryLowAlarm,
  output logic                                batteryDeadAlarm,
  output logic                                encoderInternalAlarm,
  output logic                                multiturnLost,
  output logic signed [sds_pkg::MT_W-1:0]     absolutePosition,
  output logic                                encoderAbsMode,
  output logic                                setupRefused,
  output logic                                proportionalMode,
  output logic                                analogRefUsed,
  output logic signed [sds_pkg::CMD_W-1:0]    speedCommand
);
  import sds_pkg::*;

  localparam int unsigned TICK_W = $clog2(BRAKE_STEP);

  if (BRAKE_STEP < 2) begin : g_chk
    $error("BRAKE_STEP must be at least 2");
  end

  typedef struct packed {
    sds_brake_e              brk;
    logic                    servoOn;
    logic                    almPower;
    logic [TICK_W-1:0]       tick;
    logic [LIMIT_W-1:0]      waitSteps;
    logic                    absMode;
    logic                    modeTaken;
    logic                    refused;
    logic                    pCtrl;
    logic                    anaUsed;
    logic signed [CMD_W-1:0] cmd;
    logic                    brakeOut;
  } sds_sup_s;

  sds_sup_s q, d;

  sds_enc_if encBus ();

  logic                    anyAlarm;
  logic                    slowEnough;
  logic                    timeUp;
  logic                    setupAccept;
  logic signed [CMD_W:0]   product;

  assign encBus.turnFwd     = turnFwd;
  assign encBus.turnRev     = turnRev;
  assign encBus.batClear    = batteryAlarmClearUtility;
  assign encBus.batLowIn    = batteryLowIn;
  assign encBus.batDeadIn   = batteryDeadIn;
  assign encBus.intFaultIn  = encoderFaultIn;
  assign encBus.absMode     = q.absMode;
  assign encBus.setupAccept = setupAccept;

  sds_multiturn u_multiturn (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .enc     (encBus.enc)
  );

  // battery low is a warning only and leaves the servo running
  assign anyAlarm = q.almPower | alarmIn | encBus.almBatDead |
                    encBus.almInternal;
  assign slowEnough = motorSpeed < SPEED_W'(brakeSpeedThreshold);
  assign timeUp     = q.waitSteps >= brakeTimeLimit;
  assign setupAccept = encoderSetupUtility && !q.servoOn;
  assign product = $signed(speedRefIn) * $signed({1'b0, speedInputGain});

  always_comb begin
    d         = q;
    d.refused = encoderSetupUtility && q.servoOn;
    if (!q.modeTaken) begin
      d.modeTaken = 1'b1;
      d.absMode   = encoderUsageSelect;
    end
    if (!alarmResetInputN) begin
      d.almPower = 1'b0;
    end
    if (mainPowerDip && powerLossSelect == PLOSS_ALARM) begin
      d.almPower = 1'b1;
    end
    d.servoOn = servoOnReq && !anyAlarm && q.modeTaken;
    case (q.brk)
      BRK_RELEASED: begin
        if (!d.servoOn) begin
          d.tick      = '0;
          d.waitSteps = '0;
          d.brk       = slowEnough ? BRK_APPLIED : BRK_WAIT;
        end
      end
      BRK_WAIT: begin
        if (d.servoOn) begin
          d.brk = BRK_RELEASED;
        end else if (slowEnough || timeUp) begin
          d.brk = BRK_APPLIED;
        end else if (q.tick == TICK_W'(BRAKE_STEP - 1)) begin
          d.tick      = '0;
          d.waitSteps = q.waitSteps + LIMIT_W'(1);
        end else begin
          d.tick = q.tick + TICK_W'(1);
        end
      end
      BRK_APPLIED: begin
        if (d.servoOn) begin
          d.brk = BRK_RELEASED;
        end
      end
      default: begin
        d.brk = BRK_APPLIED;
      end
    endcase
    d.brakeOut = (d.brk == BRK_APPLIED);
    d.pCtrl = !gainSelectInputN;
    d.anaUsed = sds_mode_is_analog(controlModeSelect);
    d.cmd = (d.anaUsed && q.servoOn) ? product[CMD_W-1:0] : '0;
  end

  // brake starts applied so a vertical axis holds through power-up
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '{brk: BRK_APPLIED, servoOn: 1'b0, almPower: 1'b0, tick: '0,
             waitSteps: '0, absMode: ENC_ABSOLUTE, modeTaken: 1'b0,
             refused: 1'b0, pCtrl: 1'b0, anaUsed: 1'b0, cmd: '0,
             brakeOut: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign brakeInterlockOut    = q.brakeOut;
  assign servoActive          = q.servoOn;
  assign powerLossAlarm       = q.almPower;
  assign batteryLowAlarm      = encBus.almBatLow;
  assign batteryDeadAlarm     = encBus.almBatDead;
  assign encoderInternalAlarm = encBus.almInternal;
  assign multiturnLost        = encBus.dataLost;
  assign absolutePosition     = encBus.count;
  assign encoderAbsMode       = q.absMode;
  assign setupRefused         = q.refused;
  assign proportionalMode     = q.pCtrl;
  assign analogRefUsed        = q.anaUsed;
  assign speedCommand         = q.cmd;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_brake_released;
    q.servoOn |-> !brakeInterlockOut;
  endproperty
  a_brake_released: assert property (p_brake_released)
    else $error("brake applied while servo on");

  property p_speed_apply;
    (q.brk == BRK_WAIT && slowEnough && !servoOnReq) |=> brakeInterlockOut;
  endproperty
  a_speed_apply: assert property (p_speed_apply)
    else $error("brake not applied below speed threshold");

  property p_time_apply;
    (q.brk == BRK_WAIT && timeUp && !servoOnReq) |=> brakeInterlockOut;
  endproperty
  a_time_apply: assert property (p_time_apply)
    else $error("brake not applied after time limit");

  property p_wait_released;
    (q.brk == BRK_WAIT) |-> (!brakeInterlockOut && !q.servoOn);
  endproperty
  a_wait_released: assert property (p_wait_released)
    else $error("brake output high while still waiting");

  sequence s_alarm_hit;
    anyAlarm && q.servoOn;
  endsequence
  sequence s_brake_timing;
    !q.servoOn && q.brk != BRK_RELEASED;
  endsequence
  property p_alarm_off;
    s_alarm_hit |=> s_brake_timing;
  endproperty
  a_alarm_off: assert property (p_alarm_off)
    else $error("alarm did not stop servo and start brake timing");

  // servo drops one cycle after the latched alarm, not with it
  property p_ploss_alarm;
    (mainPowerDip && powerLossSelect == PLOSS_ALARM) |=>
      q.almPower ##1 !q.servoOn;
  endproperty
  a_ploss_alarm: assert property (p_ploss_alarm)
    else $error("power dip with alarm select did not alarm");

  property p_ploss_continue;
    (mainPowerDip && powerLossSelect == PLOSS_CONTINUE && !q.almPower)
      |=> !q.almPower;
  endproperty
  a_ploss_continue: assert property (p_ploss_continue)
    else $error("power dip alarmed with continue select");

  property p_setup_refused;
    (encoderSetupUtility && q.servoOn) |-> !setupAccept ##1 setupRefused;
  endproperty
  a_setup_refused: assert property (p_setup_refused)
    else $error("setup accepted while servo on");

  property p_mode_fixed;
    q.modeTaken |=> $stable(encoderAbsMode);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("encoder usage changed without power cycle");

  property p_gain_sel;
    !gainSelectInputN |=> proportionalMode;
  endproperty
  a_gain_sel: assert property (p_gain_sel)
    else $error("low gain select did not give P control");

  property p_analog_gate;
    !sds_mode_is_analog(controlModeSelect) |=>
      (!analogRefUsed && speedCommand == '0);
  endproperty
  a_analog_gate: assert property (p_analog_gate)
    else $error("analog reference used in non-analog mode");

  property p_alarm_reset_ignored;
    (encBus.almBatDead && !alarmResetInputN && !setupAccept)
      |=> encBus.almBatDead;
  endproperty
  a_alarm_reset_ignored: assert property (p_alarm_reset_ignored)
    else $error("alarm reset cleared encoder alarm");

  property p_servo_grant;
    (servoOnReq && !anyAlarm && q.modeTaken) |=>
      (servoActive && !brakeInterlockOut);
  endproperty
  a_servo_grant: assert property (p_servo_grant)
    else $error("servo on without alarm left brake applied");

  property p_alarm_blocks;
    anyAlarm |=> !servoActive;
  endproperty
  a_alarm_blocks: assert property (p_alarm_blocks)
    else $error("servo stayed on with an alarm active");

  property p_refuse_only;
    !(encoderSetupUtility && q.servoOn) |=> !setupRefused;
  endproperty
  a_refuse_only: assert property (p_refuse_only)
    else $error("setup refused without a request while servo on");
endmodule
`default_nettype wire

// File: sim/sds_motor_model.sv
`default_nettype none
module sds_motor_model (
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  input  wire logic                        servoActive,
  input  wire logic                        brakeInterlockOut,
  input  wire logic                        coastDecay,
  input  wire logic [sds_pkg::SPEED_W-1:0] speedSet,
  output var  logic [sds_pkg::SPEED_W-1:0] motorSpeed
);
  timeunit 1ns;
  timeprecision 1ps;
  import sds_pkg::*;

  // driven motor follows the set speed, a free motor coasts down slowly
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      motorSpeed <= 16'h0000;
    end else if (servoActive) begin
      motorSpeed <= speedSet;
    end else if (brakeInterlockOut) begin
      motorSpeed <= 16'h0000;
    end else if (coastDecay && (motorSpeed != 16'h0000)) begin
      motorSpeed <= motorSpeed - 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_sds_supervisor.sv
`default_nettype none
module tb_sds_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  import sds_pkg::*;

  logic                     clk_sys;
  logic                     nrst;
  logic                     servoOnReq, alarmIn, alarmResetInputN;
  logic [SPEED_W-1:0]       motorSpeed, speedSet, speedInputGain;
  logic [THR_W-1:0]         brakeSpeedThreshold;
  logic [LIMIT_W-1:0]       brakeTimeLimit;
  logic                     powerLossSelect, mainPowerDip, coastDecay;
  logic                     encoderUsageSelect, turnFwd, turnRev;
  logic                     batteryLowIn, batteryDeadIn, encoderFaultIn;
  logic                     encoderSetupUtility, batteryAlarmClearUtility;
  logic                     gainSelectInputN;
  logic [MODE_W-1:0]        controlModeSelect;
  logic signed [SPEED_W-1:0] speedRefIn;
  logic                     brakeInterlockOut, servoActive, powerLossAlarm;
  logic                     batteryLowAlarm, batteryDeadAlarm;
  logic                     encoderInternalAlarm, multiturnLost;
  logic signed [MT_W-1:0]   absolutePosition;
  logic                     encoderAbsMode, setupRefused;
  logic                     proportionalMode, analogRefUsed;
  logic signed [CMD_W-1:0]  speedCommand;
  logic                     seen;
  logic [31:0]              expCmd;
  int                       failures = 0;
  int                       n_checks = 0;

  // short brake step keeps the time-limit path within a few dozen cycles
  sds_supervisor #(.BRAKE_STEP(4)) i_sds_supervisor (
    .clk_sys(clk_sys), .nrst(nrst), .servoOnReq(servoOnReq),
    .alarmIn(alarmIn), .alarmResetInputN(alarmResetInputN),
    .motorSpeed(motorSpeed), .brakeSpeedThreshold(brakeSpeedThreshold),
    .brakeTimeLimit(brakeTimeLimit), .powerLossSelect(powerLossSelect),
    .mainPowerDip(mainPowerDip), .encoderUsageSelect(encoderUsageSelect),
    .turnFwd(turnFwd), .turnRev(turnRev), .batteryLowIn(batteryLowIn),
    .batteryDeadIn(batteryDeadIn), .encoderFaultIn(encoderFaultIn),
    .encoderSetupUtility(encoderSetupUtility),
    .batteryAlarmClearUtility(batteryAlarmClearUtility),
    .gainSelectInputN(gainSelectInputN),
    .controlModeSelect(controlModeSelect), .speedRefIn(speedRefIn),
    .speedInputGain(speedInputGain), .brakeInterlockOut(brakeInterlockOut),
    .servoActive(servoActive), .powerLossAlarm(powerLossAlarm),
    .batteryLowAlarm(batteryLowAlarm), .batteryDeadAlarm(batteryDeadAlarm),
    .encoderInternalAlarm(encoderInternalAlarm),
    .multiturnLost(multiturnLost), .absolutePosition(absolutePosition),
    .encoderAbsMode(encoderAbsMode), .setupRefused(setupRefused),
    .proportionalMode(proportionalMode), .analogRefUsed(analogRefUsed),
    .speedCommand(speedCommand)
  );

  sds_motor_model i_sds_motor_model (
    .clk_sys(clk_sys), .nrst(nrst), .servoActive(servoActive),
    .brakeInterlockOut(brakeInterlockOut), .coastDecay(coastDecay),
    .speedSet(speedSet), .motorSpeed(motorSpeed)
  );

  always #20 clk_sys = ~clk_sys;

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // the turn counting dominates: about 33k cycles in all
  initial begin
    #3_000_000;
    failures++;
    print_verdict();
  end

  initial begin
    clk_sys = 0; nrst = 0; servoOnReq = 0; alarmIn = 0;
    alarmResetInputN = 1; speedSet = 16'h0064; speedInputGain = 16'h0005;
    brakeSpeedThreshold = 8'h0A; brakeTimeLimit = 8'h03;
    powerLossSelect = 0; mainPowerDip = 0; coastDecay = 0;
    encoderUsageSelect = 0; turnFwd = 0; turnRev = 0; batteryLowIn = 0;
    batteryDeadIn = 0; encoderFaultIn = 0; encoderSetupUtility = 0;
    batteryAlarmClearUtility = 0; gainSelectInputN = 1;
    controlModeSelect = 4'h0; speedRefIn = 16'shFFFD;
    step(2); nrst <= 1;
    look(0);
    chk(32'(brakeInterlockOut), 32'h1);
    step(1); servoOnReq <= 1;
    look(3);
    chk(32'(servoActive), 32'h1);
    chk(32'(brakeInterlockOut), 32'h0);
    step(1); gainSelectInputN <= 0;
    look(2); chk(32'(proportionalMode), 32'h1);
    step(1); gainSelectInputN <= 1;
    look(2); chk(32'(proportionalMode), 32'h0);
    for (int m = 0; m < 16; m++) begin
      step(1); controlModeSelect <= 4'(m);
      look(3);
      seen = (m == 0) || (m == 4) || (m == 7) || (m == 9) || (m == 10);
      expCmd = seen ? 32'hFFFF_FFF1 : 32'h0000_0000;
      chk(32'(analogRefUsed), 32'(seen));
      chk(speedCommand, expCmd);
    end
    // a setup request with the servo on must leave the count alone
    step(1); controlModeSelect <= 4'h0; turnFwd <= 1;
    step(5); turnFwd <= 0; encoderSetupUtility <= 1;
    step(1); encoderSetupUtility <= 0;
    look(0); seen = setupRefused;
    look(1); seen = seen | setupRefused;
    chk(32'(seen), 32'h1);
    chk({16'h0000, absolutePosition}, 32'h0000_0005);
    step(1); servoOnReq <= 0;
    look(6);
    chk(32'(servoActive), 32'h0);
    chk(32'(brakeInterlockOut), 32'h0);
    look(14); chk(32'(brakeInterlockOut), 32'h1);
    step(1); speedSet <= 16'h0014; coastDecay <= 1;
    brakeTimeLimit <= 8'h64; servoOnReq <= 1;
    step(4); servoOnReq <= 0;
    look(5); chk(32'(brakeInterlockOut), 32'h0);
    look(13); chk(32'(brakeInterlockOut), 32'h1);
    step(1); servoOnReq <= 1; mainPowerDip <= 1;
    step(1); mainPowerDip <= 0;
    look(4);
    chk(32'(powerLossAlarm), 32'h0);
    chk(32'(servoActive), 32'h1);
    step(1); powerLossSelect <= 1; mainPowerDip <= 1;
    step(1); mainPowerDip <= 0;
    look(2);
    chk(32'(powerLossAlarm), 32'h1);
    chk(32'(servoActive), 32'h0);
    chk(32'(brakeInterlockOut), 32'h0);
    look(18); chk(32'(brakeInterlockOut), 32'h1);
    step(1); alarmResetInputN <= 0;
    step(1); alarmResetInputN <= 1;
    look(4); chk(32'(powerLossAlarm), 32'h0);
    chk(32'(servoActive), 32'h1);
    step(1); alarmIn <= 1;
    look(2); chk(32'(servoActive), 32'h0);
    step(1); alarmIn <= 0; servoOnReq <= 0; encoderSetupUtility <= 1;
    step(1); encoderSetupUtility <= 0;
    look(2); chk({16'h0000, absolutePosition}, 32'h0000_0000);
    step(1); turnFwd <= 1;
    step(32767); turnFwd <= 0;
    look(1); chk({16'h0000, absolutePosition}, 32'h0000_7FFF);
    step(1); turnFwd <= 1;
    step(1); turnFwd <= 0;
    look(1); chk({16'h0000, absolutePosition}, 32'h0000_8000);
    step(1); turnRev <= 1;
    step(1); turnRev <= 0;
    look(1); chk({16'h0000, absolutePosition}, 32'h0000_7FFF);
    step(1); batteryLowIn <= 1;
    step(2); batteryLowIn <= 0; alarmResetInputN <= 0;
    step(1); alarmResetInputN <= 1; encoderSetupUtility <= 1;
    step(1); encoderSetupUtility <= 0;
    look(2); chk(32'(batteryLowAlarm), 32'h1);
    step(1); batteryAlarmClearUtility <= 1;
    step(1); batteryAlarmClearUtility <= 0;
    look(2); chk(32'(batteryLowAlarm), 32'h0);
    step(1); batteryDeadIn <= 1; servoOnReq <= 1;
    step(2); batteryDeadIn <= 0; alarmResetInputN <= 0;
    step(1); alarmResetInputN <= 1;
    look(2);
    chk(32'(batteryDeadAlarm), 32'h1);
    chk(32'(multiturnLost), 32'h1);
    chk(32'(servoActive), 32'h0);
    step(1); servoOnReq <= 0; encoderSetupUtility <= 1;
    step(1); encoderSetupUtility <= 0;
    look(2);
    chk(32'(batteryDeadAlarm), 32'h0);
    chk(32'(multiturnLost), 32'h0);
    step(1); encoderFaultIn <= 1;
    step(1); encoderFaultIn <= 0; encoderSetupUtility <= 1;
    alarmResetInputN <= 0;
    step(1); encoderSetupUtility <= 0; alarmResetInputN <= 1;
    encoderUsageSelect <= 1;
    look(3);
    chk(32'(encoderInternalAlarm), 32'h1);
    chk(32'(encoderAbsMode), 32'h0);
    step(1); nrst <= 0;
    step(2); nrst <= 1;
    look(2);
    chk(32'(encoderAbsMode), 32'h1);
    chk(32'(encoderInternalAlarm), 32'h0);
    step(1); batteryLowIn <= 1; batteryDeadIn <= 1;
    look(3);
    chk(32'(batteryLowAlarm), 32'h0);
    chk(32'(batteryDeadAlarm), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
